// File: verilog/scd_pkg.sv
// Shared constants and types of the system clock select and divide block.
// Assumes a byte-wide special-function bus and oscillator levels synchronous to CLK_I.
package scd_pkg;

  // Register location, page independent
  localparam logic [7:0] SCD_SFR_ADDR = 8'hA9;

  // Field positions
  localparam int SCD_RDY_BIT = 7;
  localparam int SCD_DIV_LSB = 4;
  localparam int SCD_RSV_BIT = 3;
  localparam int SCD_SRC_LSB = 0;

  // Reset values
  localparam logic SCD_RDY_RST = 1'b1;
  localparam logic [2:0] SCD_DIV_RST = 3'h0;
  localparam logic [2:0] SCD_SRC_RST = 3'h2;
  localparam logic [7:0] SCD_REG_RST = 8'h82;

  // Timing: a new ratio lands on the next wrap of a 128-edge counter
  localparam logic [6:0] SCD_CNT_WRAP = 7'h7F;
  localparam logic [7:0] SCD_APPLY_MAX_EDGES = 8'h80;
  localparam int SCD_NUM_SRC = 5;

  typedef enum logic [2:0] {
    SCD_SRC_PRECISION = 3'h0,
    SCD_SRC_EXTERNAL = 3'h1,
    SCD_SRC_LP_DIV8 = 3'h2,
    SCD_SRC_RTC = 3'h3,
    SCD_SRC_LP = 3'h4
  } scd_src_t;

  typedef enum logic {
    SCD_SW_IDLE = 1'b0,
    SCD_SW_BUSY = 1'b1
  } scd_sw_t;

  typedef struct packed {
    logic [2:0] div_code;
    logic [2:0] src_code;
    scd_src_t act_src;
    scd_src_t pend_src;
    scd_sw_t sw;
    logic seen_old;
    logic seen_new;
    logic [SCD_NUM_SRC-1:0] osc_prev;
    logic [7:0] rdata;
    logic rdy;
  } scd_top_st_t;

  typedef struct packed {
    logic [6:0] cnt;
    logic [2:0] cur_code;
    logic [2:0] pend_code;
    logic applied;
    logic sys_clk;
    logic sys_tick;
  } scd_div_st_t;

endpackage : scd_pkg

// File: verilog/scd_div_if.sv
// Link between the select/register logic and the divider.
// Assumes both ends run on the same clock and reset.
`timescale 1ns/1ps
`default_nettype none
interface scd_div_if;
  logic src_rise;
  logic src_level;
  logic div_req;
  logic [2:0] div_code;
  logic applied;
  logic sys_clk;
  logic sys_tick;

  modport ctl (
    output src_rise, src_level, div_req, div_code,
    input applied, sys_clk, sys_tick
  );
  modport div (
    input src_rise, src_level, div_req, div_code,
    output applied, sys_clk, sys_tick
  );
endinterface : scd_div_if
`default_nettype wire

// File: verilog/scd_divider.sv
// Power-of-two divider of the undivided source, with deferred ratio change.
// Assumes src_rise marks one rising edge of the selected oscillator per pulse.
`timescale 1ns/1ps
`default_nettype none
module scd_divider
  import scd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  scd_div_if.div dif
);

  scd_div_st_t st_reg;
  scd_div_st_t st_next;
  logic [6:0] cnt_inc;
  logic [7:0] low_mask;

  always_comb begin
    st_next = st_reg;
    cnt_inc = st_reg.cnt + 7'h01;
    low_mask = 8'((8'h01 << st_reg.cur_code) - 8'h01);
    st_next.sys_tick = 1'b0;
    if (dif.src_rise) begin
      st_next.cnt = cnt_inc;
      // Ratio changes only at the wrap so no short divided period appears
      if (st_reg.cnt == SCD_CNT_WRAP && !st_reg.applied) begin
        st_next.cur_code = st_reg.pend_code;
        st_next.applied = 1'b1;
      end
      st_next.sys_tick = ({1'b0, cnt_inc} & low_mask) == 8'h00;
    end
    if (st_reg.cur_code == 3'h0) begin
      st_next.sys_clk = dif.src_level;
    end else begin
      st_next.sys_clk = !st_next.cnt[st_reg.cur_code - 3'h1];
    end
    // A new request wins over an apply in the same cycle
    if (dif.div_req) begin
      st_next.pend_code = dif.div_code;
      st_next.applied = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '{cnt: 7'h00, cur_code: SCD_DIV_RST, pend_code: SCD_DIV_RST,
                  applied: SCD_RDY_RST, sys_clk: 1'b0, sys_tick: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign dif.applied = st_reg.applied;
  assign dif.sys_clk = st_reg.sys_clk;
  assign dif.sys_tick = st_reg.sys_tick;

  // Helper: source edges seen while a ratio is pending
  logic [7:0] wait_edges;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_edges <= 8'h00;
    end else if (st_reg.applied || dif.div_req) begin
      wait_edges <= 8'h00;
    end else if (dif.src_rise) begin
      wait_edges <= wait_edges + 8'h01;
    end
  end

  property p_req_clears_ready;
    @(posedge clk_i) disable iff (!rst_n_i)
    dif.div_req |=> !dif.applied;
  endproperty
  a_req_clears_ready: assert property (p_req_clears_ready)
    else $error("ready flag did not drop after a divide write");

  property p_apply_bound;
    @(posedge clk_i) disable iff (!rst_n_i)
    wait_edges <= SCD_APPLY_MAX_EDGES;
  endproperty
  a_apply_bound: assert property (p_apply_bound)
    else $error("divide ratio pending longer than 128 source edges");

  property p_tick_aligned;
    @(posedge clk_i) disable iff (!rst_n_i)
    dif.sys_tick |-> ({1'b0, st_reg.cnt} & low_mask) == 8'h00;
  endproperty
  a_tick_aligned: assert property (p_tick_aligned)
    else $error("divided tick not aligned to ratio boundary");

  property p_divided_level;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st_reg.cur_code != 3'h0 && !dif.src_rise && !dif.div_req)
      |=> $stable(st_reg.cur_code) && $stable(dif.sys_clk);
  endproperty
  a_divided_level: assert property (p_divided_level)
    else $error("divided clock moved without a source edge");

  c_apply: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    !dif.applied ##1 dif.applied);

endmodule : scd_divider
`default_nettype wire

// File: verilog/scd_top.sv
// System clock source select and divider with its special-function register.
// Assumes oscillator levels on OSC_I are synchronous to CLK_I, bit index = source code.
`timescale 1ns/1ps
`default_nettype none
module scd_top
  import scd_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // Special-function register port
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_WDATA_I,
  output logic [7:0] SFR_RDATA_O,
  // Oscillator levels
  input wire logic [SCD_NUM_SRC-1:0] OSC_I,
  // System clock out, active source and divide-ready status
  output logic SYSCLK_O,
  output logic SYSCLK_TICK_O,
  output logic [2:0] ACT_SRC_O,
  output logic DIV_RDY_O
);

  logic rst_meta_reg;
  logic rst_n;
  scd_top_st_t st_reg;
  scd_top_st_t st_next;
  logic [SCD_NUM_SRC-1:0] rise;
  logic hit;
  logic old_seen;
  logic new_seen;

  scd_div_if dif ();

  // Release reset through two flops; assertion stays asynchronous
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  assign rise = OSC_I & ~st_reg.osc_prev;
  assign hit = SFR_ADDR_I == SCD_SFR_ADDR;
  assign old_seen = st_reg.seen_old || rise[st_reg.act_src];
  assign new_seen = st_reg.seen_new || rise[st_reg.pend_src];

  always_comb begin
    st_next = st_reg;
    st_next.osc_prev = OSC_I;
    dif.div_req = 1'b0;
    dif.div_code = SFR_WDATA_I[SCD_DIV_LSB +: 3];
    // Old source keeps feeding the divider until the switch lands
    dif.src_rise = rise[st_reg.act_src];
    dif.src_level = OSC_I[st_reg.act_src];

    unique case (st_reg.sw)
      SCD_SW_IDLE: begin
      end
      SCD_SW_BUSY: begin
        st_next.seen_old = old_seen;
        st_next.seen_new = new_seen;
        if (old_seen && new_seen) begin
          st_next.act_src = st_reg.pend_src;
          st_next.sw = SCD_SW_IDLE;
        end
      end
    endcase

    if (SFR_WR_I && hit) begin
      st_next.div_code = SFR_WDATA_I[SCD_DIV_LSB +: 3];
      st_next.src_code = SFR_WDATA_I[SCD_SRC_LSB +: 3];
      dif.div_req = 1'b1;
      // Reserved codes are stored but never steer the clock
      if (SFR_WDATA_I[SCD_SRC_LSB +: 3] <= 3'(SCD_SRC_LP)) begin
        if (scd_src_t'(SFR_WDATA_I[SCD_SRC_LSB +: 3]) != st_next.act_src) begin
          st_next.pend_src = scd_src_t'(SFR_WDATA_I[SCD_SRC_LSB +: 3]);
          st_next.sw = SCD_SW_BUSY;
          st_next.seen_old = 1'b0;
          st_next.seen_new = 1'b0;
        end else begin
          st_next.pend_src = st_next.act_src;
          st_next.sw = SCD_SW_IDLE;
        end
      end
    end

    if (SFR_RD_I) begin
      if (hit) begin
        st_next.rdata = 8'h00;
        st_next.rdata[SCD_RDY_BIT] = dif.applied;
        st_next.rdata[SCD_DIV_LSB +: 3] = st_reg.div_code;
        st_next.rdata[SCD_RSV_BIT] = 1'b0;
        st_next.rdata[SCD_SRC_LSB +: 3] = st_reg.src_code;
      end else begin
        st_next.rdata = 8'h00;
      end
    end
    st_next.rdy = dif.applied;
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{div_code: SCD_DIV_RST, src_code: SCD_SRC_RST,
                  act_src: SCD_SRC_LP_DIV8, pend_src: SCD_SRC_LP_DIV8,
                  sw: SCD_SW_IDLE, seen_old: 1'b0, seen_new: 1'b0,
                  osc_prev: '0, rdata: SCD_REG_RST, rdy: SCD_RDY_RST};
    end else begin
      st_reg <= st_next;
    end
  end

  scd_divider u_div (
    .clk_i(CLK_I),
    .rst_n_i(rst_n),
    .dif(dif)
  );

  assign SFR_RDATA_O = st_reg.rdata;
  assign SYSCLK_O = dif.sys_clk;
  assign SYSCLK_TICK_O = dif.sys_tick;
  assign ACT_SRC_O = st_reg.act_src;
  assign DIV_RDY_O = st_reg.rdy;

  property p_bit3_zero;
    @(posedge CLK_I) disable iff (!rst_n)
    (SFR_RD_I && hit) |=> !SFR_RDATA_O[SCD_RSV_BIT];
  endproperty
  a_bit3_zero: assert property (p_bit3_zero)
    else $error("reserved bit 3 read back as one");

  property p_write_read;
    @(posedge CLK_I) disable iff (!rst_n)
    (SFR_WR_I && hit ##1 SFR_RD_I && hit && !SFR_WR_I)
      |=> SFR_RDATA_O[6:4] == $past(SFR_WDATA_I[6:4], 2);
  endproperty
  a_write_read: assert property (p_write_read)
    else $error("divide field did not read back at its address");

  property p_switch_waits_old;
    @(posedge CLK_I) disable iff (!rst_n)
    (st_reg.sw == SCD_SW_BUSY && !old_seen && !(SFR_WR_I && hit))
      |=> st_reg.act_src == $past(st_reg.act_src);
  endproperty
  a_switch_waits_old: assert property (p_switch_waits_old)
    else $error("source switched before a full old oscillator period");

  property p_switch_lands;
    @(posedge CLK_I) disable iff (!rst_n)
    (st_reg.sw == SCD_SW_BUSY && old_seen && new_seen && !(SFR_WR_I && hit))
      |=> st_reg.act_src == $past(st_reg.pend_src) && st_reg.sw == SCD_SW_IDLE;
  endproperty
  a_switch_lands: assert property (p_switch_lands)
    else $error("source switch did not complete after both periods");

  property p_act_legal;
    @(posedge CLK_I) disable iff (!rst_n)
    ACT_SRC_O <= 3'(SCD_SRC_LP);
  endproperty
  a_act_legal: assert property (p_act_legal)
    else $error("active source holds a reserved code");

  property p_reserved_ignored;
    @(posedge CLK_I) disable iff (!rst_n)
    (SFR_WR_I && hit && SFR_WDATA_I[2:0] > 3'(SCD_SRC_LP) && st_reg.sw == SCD_SW_IDLE)
      |=> $stable(st_reg.act_src) && st_reg.sw == SCD_SW_IDLE;
  endproperty
  a_reserved_ignored: assert property (p_reserved_ignored)
    else $error("reserved source code started a switch");

  property p_reset_value;
    @(posedge CLK_I) disable iff (!rst_n)
    !$past(rst_n) |-> SFR_RDATA_O == SCD_REG_RST && DIV_RDY_O && ACT_SRC_O == 3'h2;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("state after reset differs from 0x82");

  c_switch: cover property (@(posedge CLK_I) disable iff (!rst_n)
    st_reg.sw == SCD_SW_BUSY ##1 st_reg.sw == SCD_SW_IDLE);
  c_div_write: cover property (@(posedge CLK_I) disable iff (!rst_n)
    SFR_WR_I && hit && SFR_WDATA_I[6:4] == 3'h7);
  c_read: cover property (@(posedge CLK_I) disable iff (!rst_n)
    SFR_RD_I && hit && !DIV_RDY_O);

endmodule : scd_top
`default_nettype wire

// File: verification/scd_top_test.sv
// Self-checking bench of the clock select and divide block.
// Assumes oscillator levels are made here, synchronous to the 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module scd_top_test;
  import scd_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [4:0] osc = 5'h00;
  logic [2:0] ocnt = 3'h0;
  logic sysclk;
  logic tick;
  logic rdy;
  logic [2:0] act;
  int errors = 0;
  int cmp_count = 0;

  always #20 clk = ~clk;
  // Sources of period 2, 4, 8, 4 and 2 cycles
  always @(posedge clk) begin
    ocnt <= ocnt + 3'h1;
    osc <= {ocnt[0], ocnt[1], ocnt[2], ocnt[1], ocnt[0]};
  end

  scd_top i_dut (
    .CLK_I(clk), .NRST_I(nrst), .SFR_ADDR_I(addr), .SFR_WR_I(wr), .SFR_RD_I(rd),
    .SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata), .OSC_I(osc), .SYSCLK_O(sysclk),
    .SYSCLK_TICK_O(tick), .ACT_SRC_O(act), .DIV_RDY_O(rdy)
  );

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Write, then read in the very next cycle, as software would poll
  task automatic access(input logic [7:0] wa, input logic [7:0] wd, input logic [7:0] ra,
                        output logic [7:0] q);
    @(posedge clk);
    addr <= wa;
    wdata <= wd;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ra;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    q = rdata;
  endtask : access

  // Kind 0 ready, 1 tick, 2 active source equals want
  task automatic wait_until(input int kind, input logic [2:0] want, input int lim, output int n);
    n = 0;
    while (!(kind == 0 ? rdy === 1'b1 : kind == 1 ? tick === 1'b1 : act === want)) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        errors++;
        $display("wait limit reached, kind %0d", kind);
        report_and_stop();
      end
    end
  endtask : wait_until

  task automatic t_reset();
    logic [7:0] q;
    // Look between edges, away from the launching edge
    @(negedge clk);
    check("ready after reset", rdy, 1);
    check("source after reset", act, 2);
    access(8'h00, 8'hFF, SCD_SFR_ADDR, q);
    check("reset value", q, 8'h82);
    access(8'hAA, 8'h70, 8'hAA, q);
    check("unmapped read", q, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_sources();
    logic [2:0] seq [4] = '{3'h1, 3'h3, 3'h4, 3'h0};
    logic [7:0] q;
    int n;
    foreach (seq[i]) begin
      // Bit 3 and bit 7 set on purpose: both must be dropped
      access(SCD_SFR_ADDR, {5'h11, seq[i]}, SCD_SFR_ADDR, q);
      check("source readback", q[3:0], {1'b0, seq[i]});
      wait_until(2, seq[i], 20, n);
      check("active source", act, seq[i]);
      // Slowest source here has a 4-cycle period: 128 edges take 512 cycles
      wait_until(0, 3'h0, 600, n);
    end
    // Reserved code, which software must avoid, is only stored
    access(SCD_SFR_ADDR, 8'h0D, SCD_SFR_ADDR, q);
    check("reserved readback", q[3:0], 4'h5);
    repeat (20) @(posedge clk);
    check("source kept", act, 3'h0);
    access(SCD_SFR_ADDR, 8'h00, SCD_SFR_ADDR, q);
    wait_until(0, 3'h0, 264, n);
    $display("test sources done");
  endtask : t_sources

  task automatic t_divide();
    logic [7:0] q;
    int n;
    for (int c = 0; c < 8; c++) begin
      access(SCD_SFR_ADDR, {1'b0, c[2:0], 4'h0}, SCD_SFR_ADDR, q);
      check("divide readback", q, {1'b0, c[2:0], 4'h0});
      check("ready low while pending", rdy, 0);
      wait_until(0, 3'h0, 264, n);
      // 128 edges of a 2-cycle source, plus two cycles of latency
      check("ready within 128 edges", {15'h0, n <= 2 * 128 + 2}, 16'h1);
      wait_until(1, 3'h0, 300, n);
      check("sysclk high at tick", sysclk, 1);
      repeat (1 << c) @(negedge clk);
      check("sysclk low half way", sysclk, 0);
      wait_until(1, 3'h0, 300, n);
      // Source 0 toggles every cycle, so one source period is 2 cycles
      check("tick spacing", 16'(n + (1 << c)), 16'd2 << c);
    end
    // Back to divide by 1, as required before a low-power mode
    // Undivided 12.5 MHz: software would also bypass the flash one-shot
    access(SCD_SFR_ADDR, 8'h00, SCD_SFR_ADDR, q);
    wait_until(0, 3'h0, 264, n);
    $display("test divide done");
  endtask : t_divide

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_sources();
    t_divide();
    report_and_stop();
  end
endmodule : scd_top_test
`default_nettype wire
